//--- core/serial_link_test_pkg.sv
package serial_link_test_pkg;

    // lane, link and transport geometry
    localparam int NUM_LANES      = 8;
    localparam int LANES_PER_LINK = 4;
    localparam int NUM_LINKS      = 2;
    localparam int LANE_W         = 16;
    localparam int NUM_CONV       = 4;
    localparam int NUM_SLOTS      = 4;
    localparam int SAMPLE_W       = 16;
    localparam int TALLY_W        = 24;
    localparam int HIST_W         = 31;
    localparam int ERRS_W         = 5;

    // register addresses on the serial port
    localparam int ADDR_W = 15;
    localparam logic [14:0] ADDR_LINK_SEL     = 15'h300;
    localparam logic [14:0] ADDR_LANE_EN      = 15'h315;
    localparam logic [14:0] ADDR_PAT_CTRL     = 15'h316;
    localparam logic [14:0] ADDR_LIMIT_0      = 15'h317;
    localparam logic [14:0] ADDR_LIMIT_1      = 15'h318;
    localparam logic [14:0] ADDR_LIMIT_2      = 15'h319;
    localparam logic [14:0] ADDR_TALLY_0      = 15'h31a;
    localparam logic [14:0] ADDR_TALLY_1      = 15'h31b;
    localparam logic [14:0] ADDR_TALLY_2      = 15'h31c;
    localparam logic [14:0] ADDR_PASS         = 15'h31d;
    localparam logic [14:0] ADDR_SC_CTRL      = 15'h32c;
    localparam logic [14:0] ADDR_EXPECT_A     = 15'h32d;
    localparam logic [14:0] ADDR_EXPECT_B     = 15'h32e;
    localparam logic [14:0] ADDR_SC_RESULT    = 15'h32f;
    localparam logic [14:0] ADDR_CGS_STATUS   = 15'h470;
    localparam logic [14:0] ADDR_ILAS_STATUS  = 15'h473;
    localparam logic [14:0] ADDR_ILAS_MODE    = 15'h477;

    // field positions
    localparam int LINK_SEL_BIT   = 2;
    localparam int PC_CLEAR_BIT   = 0;
    localparam int PC_GO_BIT      = 1;
    localparam int PC_CHOICE_LSB  = 2;
    localparam int PC_LANE_LSB    = 4;
    localparam int SC_ENABLE_BIT  = 0;
    localparam int SC_CLEAR_BIT   = 1;
    localparam int SC_CONV_LSB    = 2;
    localparam int SC_INDEX_LSB   = 4;
    localparam int ILAS_MODE_BIT  = 7;
    localparam logic [7:0] PC_WR_MASK = 8'h7f;
    localparam logic [7:0] SC_WR_MASK = 8'h3f;

    // reset values
    localparam logic [7:0]  RST_BYTE  = 8'h00;
    localparam logic [23:0] RST_LIMIT = 24'h000000;

    // pattern choice codes
    localparam logic [1:0] PAT_P7  = 2'h0;
    localparam logic [1:0] PAT_P15 = 2'h1;

    // link characters and counts
    localparam logic [7:0] CHAR_COMMA = 8'hbc;
    localparam logic [7:0] CHAR_MF_START = 8'h1c;
    localparam logic [7:0] CHAR_MF_END = 8'h7c;
    localparam logic [2:0] CGS_NEEDED = 3'h4;
    localparam logic [1:0] PRIME_WORDS = 2'(((HIST_W + LANE_W - 1) / LANE_W));
    localparam logic [4:0] SPI_INSTR_LAST = 5'h0f;
    localparam logic [4:0] SPI_FRAME_LAST = 5'h17;
    localparam logic [4:0] SPI_FRAME_BITS = 5'h18;

    // carriers
    typedef struct packed {
        logic [NUM_LANES-1:0][LANE_W-1:0] data;
        logic [NUM_LANES-1:0]             valid;
    } lane_words_t;

    typedef struct packed {
        logic [NUM_LANES-1:0][7:0] chr;
        logic [NUM_LANES-1:0]      isK;
        logic [NUM_LANES-1:0]      valid;
    } lane_chars_t;

    typedef struct packed {
        logic [NUM_CONV-1:0][NUM_SLOTS-1:0][SAMPLE_W-1:0] sample;
        logic                                             valid;
    } tpl_frame_t;

    typedef struct packed {
        logic [HIST_W-1:0] hist;
        logic [ERRS_W-1:0] errs;
    } prbs_step_t;

endpackage : serial_link_test_pkg

//--- core/serial_link_test_checker.sv
`timescale 1ns/1ps
// Operation
// - per-lane pattern checker, works with no link up
// - two-bit choice: 7, 15 or 31 bit polynomial, default 7
// - one enable bit per lane; lanes checked in any mix
// - clear bit pulse clears checker state
// - error limit is held in three consecutive byte registers
// - test runs from rising edge of go bit until go written 0
// - one pass bit per lane after the test, 1 pass, 0 fail
// - three-bit selector picks the lane whose tally is read
// - lane tally 24-bit saturating; all ones means overflowed
// - one selected converter sample is compared against an expected value
// - two-bit converter and two-bit slot fields select it
// - expected 16-bit sample is held in two byte registers
// - sample comparison runs only while its enable bit is 1
// - sample clear pulse restarts the comparison
// - one status bit reports sample result, 0 pass, 1 mismatch
// - checks a comma stream, or commas then alignment sequences
// - commas release sync request; per-lane comma status readable
// - link select bit chooses which link's lane status is shown
// - sync released after four commas on each enabled lane
// - alignment test mode bit enables repeated alignment checks
module serial_link_test_checker
    import serial_link_test_pkg::*;
(
    // clock and reset
    input  wire logic                 clk,
    input  wire logic                 nrst,
    // serial register port
    input  wire logic                 spiCsN,
    input  wire logic                 spiClk,
    input  wire logic                 spiDataIn,
    output logic                      spiDataOut,
    output logic                      spiDataOutEn,
    // physical lane words and decoded link characters
    input  wire lane_words_t          laneWords,
    input  wire lane_chars_t          laneChars,
    input  wire logic [NUM_LANES-1:0] linkLaneEnable,
    input  wire logic                 dualLinkMode,
    // transport layer samples
    input  wire tpl_frame_t           tplFrame,
    // sync request per link, low asks the transmitter to resync
    output logic [NUM_LINKS-1:0]      syncRequestOutN
);

    // one pattern step over a whole word, oldest bit first, self-synchronising
    function automatic prbs_step_t prbs_step(input logic [HIST_W-1:0] hist,
                                             input logic [LANE_W-1:0] word,
                                             input logic [1:0]        choice);
        prbs_step_t r;
        logic       expBit;
        r.hist = hist;
        r.errs = '0;
        for (int i = LANE_W - 1; i >= 0; i--)
        begin
            case (choice)
                PAT_P7:  expBit = r.hist[6] ^ r.hist[5];
                PAT_P15: expBit = r.hist[14] ^ r.hist[13];
                default: expBit = r.hist[30] ^ r.hist[27];
            endcase
            if (word[i] != expBit)
                r.errs = r.errs + 5'h01;
            r.hist = {r.hist[HIST_W-2:0], word[i]};
        end
        return r;
    endfunction : prbs_step

    // saturating add, all ones stays all ones
    function automatic logic [TALLY_W-1:0] sat_add(input logic [TALLY_W-1:0] a,
                                                   input logic [ERRS_W-1:0]  e);
        logic [TALLY_W:0] sum;
        sum = {1'b0, a} + {{(TALLY_W + 1 - ERRS_W){1'b0}}, e};
        return sum[TALLY_W] ? {TALLY_W{1'b1}} : sum[TALLY_W-1:0];
    endfunction : sat_add

    // reset release through two flops
    logic rstMeta_reg;
    logic rstN_reg;
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rstMeta_reg <= 1'b0;
            rstN_reg    <= 1'b0;
        end
        else
        begin
            rstMeta_reg <= 1'b1;
            rstN_reg    <= rstMeta_reg;
        end
    end

    // serial port framing: r/w bit, 15-bit address, 8-bit data, msb first
    logic        sclkPrev_reg;
    logic [4:0]  bitCnt_reg;
    logic [22:0] inShift_reg;
    logic [7:0]  outShift_reg;
    logic        readOp_reg;
    logic        sclkRise;
    logic        sclkFall;
    logic        wrStrobe;
    logic [14:0] wrAddr;
    logic [7:0]  wrData;
    logic [14:0] rdAddr;
    logic [7:0]  readByte;

    assign sclkRise = spiClk && !sclkPrev_reg;
    assign sclkFall = !spiClk && sclkPrev_reg;
    assign wrStrobe = !spiCsN && sclkRise && (bitCnt_reg == SPI_FRAME_LAST) && !inShift_reg[22];
    assign wrAddr   = inShift_reg[21:7];
    assign wrData   = {inShift_reg[6:0], spiDataIn};
    assign rdAddr   = {inShift_reg[13:0], spiDataIn};

    // counter stops after one frame; extra bits ignored until deselect
    always_ff @(posedge clk or negedge rstN_reg)
    begin
        if (!rstN_reg)
        begin
            sclkPrev_reg <= 1'b0;
            bitCnt_reg   <= 5'h00;
            inShift_reg  <= 23'h000000;
        end
        else
        begin
            sclkPrev_reg <= spiClk;
            if (spiCsN)
                bitCnt_reg <= 5'h00;
            else if (sclkRise && bitCnt_reg != SPI_FRAME_BITS)
            begin
                bitCnt_reg  <= bitCnt_reg + 5'h01;
                inShift_reg <= {inShift_reg[21:0], spiDataIn};
            end
        end
    end

    // read data is launched on falling edges so the master samples on rising
    always_ff @(posedge clk or negedge rstN_reg)
    begin
        if (!rstN_reg)
        begin
            outShift_reg <= 8'h00;
            readOp_reg   <= 1'b0;
            spiDataOut   <= 1'b0;
            spiDataOutEn <= 1'b0;
        end
        else if (spiCsN)
        begin
            readOp_reg   <= 1'b0;
            spiDataOut   <= 1'b0;
            spiDataOutEn <= 1'b0;
        end
        else if (sclkRise && bitCnt_reg == SPI_INSTR_LAST)
        begin
            outShift_reg <= readByte;
            readOp_reg   <= inShift_reg[14];
        end
        else if (sclkFall && readOp_reg && bitCnt_reg > SPI_INSTR_LAST
                 && bitCnt_reg != SPI_FRAME_BITS)
        begin
            spiDataOut   <= outShift_reg[7];
            outShift_reg <= {outShift_reg[6:0], 1'b0};
            spiDataOutEn <= 1'b1;
        end
    end

    // software registers
    logic [7:0]          linkSel_reg;
    logic [7:0]          laneEnable_reg;
    logic [7:0]          patCtrl_reg;
    logic [TALLY_W-1:0]  limit_reg;
    logic [7:0]          sampleCtrl_reg;
    logic [SAMPLE_W-1:0] expected_reg;
    logic                ilasMode_reg;

    // writes to read-only addresses are dropped
    always_ff @(posedge clk or negedge rstN_reg)
    begin
        if (!rstN_reg)
        begin
            linkSel_reg    <= RST_BYTE;
            laneEnable_reg <= RST_BYTE;
            patCtrl_reg    <= RST_BYTE;
            limit_reg      <= RST_LIMIT;
            sampleCtrl_reg <= RST_BYTE;
            expected_reg   <= {RST_BYTE, RST_BYTE};
            ilasMode_reg   <= 1'b0;
        end
        else if (wrStrobe)
        begin
            case (wrAddr)
                ADDR_LINK_SEL:  linkSel_reg        <= wrData;
                ADDR_LANE_EN:   laneEnable_reg     <= wrData;
                ADDR_PAT_CTRL:  patCtrl_reg        <= wrData & PC_WR_MASK;
                ADDR_LIMIT_0:   limit_reg[7:0]     <= wrData;
                ADDR_LIMIT_1:   limit_reg[15:8]    <= wrData;
                ADDR_LIMIT_2:   limit_reg[23:16]   <= wrData;
                ADDR_SC_CTRL:   sampleCtrl_reg     <= wrData & SC_WR_MASK;
                ADDR_EXPECT_A:  expected_reg[7:0]  <= wrData;
                ADDR_EXPECT_B:  expected_reg[15:8] <= wrData;
                ADDR_ILAS_MODE: ilasMode_reg       <= wrData[ILAS_MODE_BIT];
                default:        ;
            endcase
        end
    end

    // go and both clears act on their rising edges
    logic goPrev_reg;
    logic patClrPrev_reg;
    logic scClrPrev_reg;
    logic run_reg;
    logic goRise;
    logic patClear;
    logic scClear;
    assign goRise   = patCtrl_reg[PC_GO_BIT] && !goPrev_reg;
    assign patClear = patCtrl_reg[PC_CLEAR_BIT] && !patClrPrev_reg;
    assign scClear  = sampleCtrl_reg[SC_CLEAR_BIT] && !scClrPrev_reg;

    always_ff @(posedge clk or negedge rstN_reg)
    begin
        if (!rstN_reg)
        begin
            goPrev_reg     <= 1'b0;
            patClrPrev_reg <= 1'b0;
            scClrPrev_reg  <= 1'b0;
            run_reg        <= 1'b0;
        end
        else
        begin
            goPrev_reg     <= patCtrl_reg[PC_GO_BIT];
            patClrPrev_reg <= patCtrl_reg[PC_CLEAR_BIT];
            scClrPrev_reg  <= sampleCtrl_reg[SC_CLEAR_BIT];
            if (!patCtrl_reg[PC_GO_BIT])
                run_reg <= 1'b0;
            else if (goRise)
                run_reg <= 1'b1;
        end
    end

    // per-lane pattern checkers
    logic [HIST_W-1:0]  hist_reg  [NUM_LANES];
    logic [1:0]         prime_reg [NUM_LANES];
    logic [TALLY_W-1:0] tally_reg [NUM_LANES];
    logic [NUM_LANES-1:0] pass_reg;
    prbs_step_t         step      [NUM_LANES];
    logic [TALLY_W-1:0] tallyNext [NUM_LANES];

    always_comb
    begin
        for (int l = 0; l < NUM_LANES; l++)
        begin
            step[l]      = prbs_step(hist_reg[l], laneWords.data[l],
                                     patCtrl_reg[PC_CHOICE_LSB +: 2]);
            tallyNext[l] = sat_add(tally_reg[l], step[l].errs);
        end
    end

    // history follows the line outside runs too; the
    // first words only fill it
    always_ff @(posedge clk or negedge rstN_reg)
    begin
        if (!rstN_reg)
        begin
            pass_reg <= '1;
            for (int l = 0; l < NUM_LANES; l++)
            begin
                hist_reg[l]  <= '0;
                prime_reg[l] <= 2'h0;
                tally_reg[l] <= '0;
            end
        end
        else
        begin
            for (int l = 0; l < NUM_LANES; l++)
            begin
                if (patClear)
                begin
                    hist_reg[l]  <= '0;
                    prime_reg[l] <= 2'h0;
                    tally_reg[l] <= '0;
                    pass_reg[l]  <= 1'b1;
                end
                else if (laneEnable_reg[l] && laneWords.valid[l])
                begin
                    hist_reg[l] <= step[l].hist;
                    if (prime_reg[l] != PRIME_WORDS)
                        prime_reg[l] <= prime_reg[l] + 2'h1;
                    else if (run_reg)
                    begin
                        tally_reg[l] <= tallyNext[l];
                        if (tallyNext[l] != '0 && tallyNext[l] >= limit_reg)
                            pass_reg[l] <= 1'b0;
                    end
                end
            end
        end
    end

    // transport sample check; a mismatch in the clear cycle still lands
    logic                mismatch_reg;
    logic [SAMPLE_W-1:0] selSample;
    assign selSample = tplFrame.sample[sampleCtrl_reg[SC_CONV_LSB +: 2]]
                                      [sampleCtrl_reg[SC_INDEX_LSB +: 2]];

    always_ff @(posedge clk or negedge rstN_reg)
    begin
        if (!rstN_reg)
            mismatch_reg <= 1'b0;
        else if (sampleCtrl_reg[SC_ENABLE_BIT] && tplFrame.valid
                 && selSample != expected_reg)
            mismatch_reg <= 1'b1;
        else if (scClear)
            mismatch_reg <= 1'b0;
    end

    // comma and alignment tracking per lane
    logic [2:0]           cgsCnt_reg [NUM_LANES];
    logic [NUM_LANES-1:0] cgsPass_reg;
    logic [NUM_LANES-1:0] mfStart_reg;
    logic [NUM_LANES-1:0] ilasPass_reg;
    logic [NUM_LANES-1:0] isComma;
    logic [NUM_LANES-1:0] isMfStart;
    logic [NUM_LANES-1:0] isMfEnd;

    always_comb
    begin
        for (int l = 0; l < NUM_LANES; l++)
        begin
            isComma[l]   = laneChars.valid[l] && laneChars.isK[l]
                           && laneChars.chr[l] == CHAR_COMMA;
            isMfStart[l] = laneChars.valid[l] && laneChars.isK[l]
                           && laneChars.chr[l] == CHAR_MF_START;
            isMfEnd[l]   = laneChars.valid[l] && laneChars.isK[l]
                           && laneChars.chr[l] == CHAR_MF_END;
        end
    end

    // comma pass is sticky, kept through the alignment stream
    always_ff @(posedge clk or negedge rstN_reg)
    begin
        if (!rstN_reg)
        begin
            cgsPass_reg  <= '0;
            mfStart_reg  <= '0;
            ilasPass_reg <= '0;
            for (int l = 0; l < NUM_LANES; l++)
                cgsCnt_reg[l] <= 3'h0;
        end
        else
        begin
            for (int l = 0; l < NUM_LANES; l++)
            begin
                if (!linkLaneEnable[l])
                begin
                    cgsCnt_reg[l]   <= 3'h0;
                    cgsPass_reg[l]  <= 1'b0;
                    mfStart_reg[l]  <= 1'b0;
                    ilasPass_reg[l] <= 1'b0;
                end
                else if (!cgsPass_reg[l])
                begin
                    if (isComma[l])
                    begin
                        cgsCnt_reg[l] <= cgsCnt_reg[l] + 3'h1;
                        if (cgsCnt_reg[l] + 3'h1 == CGS_NEEDED)
                            cgsPass_reg[l] <= 1'b1;
                    end
                    else if (laneChars.valid[l])
                        cgsCnt_reg[l] <= 3'h0;
                end
                else if (ilasMode_reg)
                begin
                    if (isMfStart[l])
                        mfStart_reg[l] <= 1'b1;
                    if (isMfEnd[l] && mfStart_reg[l])
                        ilasPass_reg[l] <= 1'b1;
                end
            end
        end
    end

    // sync released once every enabled lane of the link has commas
    logic [NUM_LANES-1:0] laneOk;
    logic                 allOk;
    logic                 lowOk;
    logic                 highOk;
    assign laneOk = cgsPass_reg | ~linkLaneEnable;
    assign lowOk  = &laneOk[LANES_PER_LINK-1:0] && |linkLaneEnable[LANES_PER_LINK-1:0];
    assign highOk = &laneOk[NUM_LANES-1:LANES_PER_LINK]
                    && |linkLaneEnable[NUM_LANES-1:LANES_PER_LINK];
    assign allOk  = &laneOk && |linkLaneEnable;

    always_ff @(posedge clk or negedge rstN_reg)
    begin
        if (!rstN_reg)
            syncRequestOutN <= '0;
        else if (dualLinkMode)
            syncRequestOutN <= {highOk, lowOk};
        else
            syncRequestOutN <= {allOk, allOk};
    end

    // register read data
    logic [TALLY_W-1:0]        selTally;
    logic [LANES_PER_LINK-1:0] cgsShown;
    logic [LANES_PER_LINK-1:0] ilasShown;
    assign selTally  = tally_reg[patCtrl_reg[PC_LANE_LSB +: 3]];
    assign cgsShown  = linkSel_reg[LINK_SEL_BIT] ? cgsPass_reg[NUM_LANES-1:LANES_PER_LINK]
                                                 : cgsPass_reg[LANES_PER_LINK-1:0];
    assign ilasShown = linkSel_reg[LINK_SEL_BIT] ? ilasPass_reg[NUM_LANES-1:LANES_PER_LINK]
                                                 : ilasPass_reg[LANES_PER_LINK-1:0];

    always_comb
    begin
        readByte = 8'h00;
        case (rdAddr)
            ADDR_LINK_SEL:    readByte = linkSel_reg;
            ADDR_LANE_EN:     readByte = laneEnable_reg;
            ADDR_PAT_CTRL:    readByte = patCtrl_reg;
            ADDR_LIMIT_0:     readByte = limit_reg[7:0];
            ADDR_LIMIT_1:     readByte = limit_reg[15:8];
            ADDR_LIMIT_2:     readByte = limit_reg[23:16];
            ADDR_TALLY_0:     readByte = selTally[7:0];
            ADDR_TALLY_1:     readByte = selTally[15:8];
            ADDR_TALLY_2:     readByte = selTally[23:16];
            ADDR_PASS:        readByte = pass_reg;
            ADDR_SC_CTRL:     readByte = sampleCtrl_reg;
            ADDR_EXPECT_A:    readByte = expected_reg[7:0];
            ADDR_EXPECT_B:    readByte = expected_reg[15:8];
            ADDR_SC_RESULT:   readByte = {7'h00, mismatch_reg};
            ADDR_CGS_STATUS:  readByte = {4'h0, cgsShown};
            ADDR_ILAS_STATUS: readByte = {4'h0, ilasShown};
            ADDR_ILAS_MODE:   readByte = {ilasMode_reg, 7'h00};
            default:          readByte = 8'h00;
        endcase
    end

endmodule : serial_link_test_checker

//--- verification/serial_link_test_checker_assertions.sv
`timescale 1ns/1ps
module serial_link_test_checker_assertions
    import serial_link_test_pkg::*;
(
    // clock and reset
    input wire logic                 clk,
    input wire logic                 nrst,
    // register port
    input wire logic                 spiCsN,
    input wire logic                 spiClk,
    input wire logic                 spiDataOut,
    input wire logic                 spiDataOutEn,
    // link side
    input wire lane_chars_t          laneChars,
    input wire logic [NUM_LANES-1:0] linkLaneEnable,
    input wire logic [NUM_LINKS-1:0] syncRequestOutN
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    // K characters seen on enabled lanes
    wire logic [7:0] kSeen = laneChars.valid & laneChars.isK & linkLaneEnable;
    wire logic [3:0] kHigh = kSeen[7:4];
    a_reset_quiet: assert property
        (disable iff (1'b0) !nrst |-> !spiDataOutEn && syncRequestOutN == 2'b00)
        else $error("outputs active in reset");
    a_oe_idle: assert property ($past(spiCsN) |-> !spiDataOutEn)
        else $error("read driver on while deselected");
    a_oe_rise: assert property ($rose(spiDataOutEn) |-> !spiClk && !spiCsN)
        else $error("read driver on outside a low serial clock");
    a_out_on_fall: assert property
        (spiDataOutEn && $past(spiDataOutEn) && $changed(spiDataOut) |-> !spiClk)
        else $error("read bit moved while serial clock high");
    a_sync_no_lanes: assert property (linkLaneEnable == 8'h00 && $past(linkLaneEnable) == 8'h00
        && $past(linkLaneEnable, 2) == 8'h00 |-> syncRequestOutN == 2'b00) else $error("released idle");
    a_sync_first_comma: assert property ($rose(syncRequestOutN[0]) |-> $past(kSeen) != 8'h00)
        else $error("link 0 released without comma");
    a_sync_second_comma: assert property ($rose(syncRequestOutN[1]) |-> $past(kHigh) != 4'h0)
        else $error("link 1 released without comma");
    a_sync_sticky: assert property (syncRequestOutN[0] && $stable(linkLaneEnable) |=> syncRequestOutN[0])
        else $error("link 0 request returned");
endmodule : serial_link_test_checker_assertions

bind serial_link_test_checker serial_link_test_checker_assertions i_chk (
    .clk, .nrst, .spiCsN, .spiClk, .spiDataOut, .spiDataOutEn,
    .laneChars, .linkLaneEnable, .syncRequestOutN
);

//--- verification/link_tx_model.sv
`timescale 1ns/1ps
module link_tx_model
    import serial_link_test_pkg::*;
(
    // clock and what to send: 0 idle, 1 commas, 2 pattern, 3 samples
    input  wire logic       clk,
    input  wire logic [1:0] mode,
    input  wire logic       flipBit,
    // link side
    output lane_words_t     laneWords,
    output lane_chars_t     laneChars,
    output tpl_frame_t      tplFrame
);
    logic [6:0]  seq = 7'h7f;
    logic [15:0] word = 16'h0000;
    // 7-bit polynomial runs always, so it flows before setup
    always @(posedge clk)
    begin : gen
        logic [6:0]  s;
        logic [15:0] w;
        s = seq;
        for (int b = 15; b >= 0; b--)
        begin
            w[b] = s[6] ^ s[5];
            s = {s[5:0], w[b]};
        end
        seq <= s;
        word <= w;
    end
    // idle lines still toggle
    always_comb
    begin
        for (int n = 0; n < NUM_LANES; n++)
        begin
            laneWords.data[n] = (mode == 2'h2) ? word : ~word;
            laneChars.chr[n] = (mode == 2'h1) ? CHAR_COMMA : word[7:0];
        end
        laneWords.data[0][0] = laneWords.data[0][0] ^ flipBit;
        laneWords.valid = {NUM_LANES{mode == 2'h2}};
        laneChars.isK = {NUM_LANES{mode == 2'h1}};
        laneChars.valid = {NUM_LANES{mode == 2'h1}};
        for (int c = 0; c < NUM_CONV; c++)
            for (int s = 0; s < NUM_SLOTS; s++)
                tplFrame.sample[c][s] = 16'h0a00 + 16'(NUM_SLOTS * c + s);
        tplFrame.valid = (mode == 2'h3);
    end
endmodule : link_tx_model

//--- verification/serial_link_test_checker_tb.sv
`timescale 1ns/1ps
module serial_link_test_checker_tb
    import serial_link_test_pkg::*;
;
    typedef struct packed {
        logic [14:0] a;
        logic [7:0]  d;
        logic [7:0]  q;
    } row_t;
    logic        clk = 1'b0;
    logic        nrst = 1'b1;
    logic        spiCsN = 1'b1;
    logic        spiClk = 1'b0;
    logic        spiDataIn = 1'b0;
    logic [7:0]  linkLaneEnable = 8'h00;
    logic        dualLinkMode = 1'b1;
    logic [1:0]  mode = 2'h0;
    logic        flipBit = 1'b0;
    logic        spiDataOut;
    logic        spiDataOutEn;
    logic [1:0]  syncRequestOutN;
    lane_words_t laneWords;
    lane_chars_t laneChars;
    tpl_frame_t  tplFrame;
    logic [7:0]  q;
    int          errTotal = 0;
    int          checks = 0;
    // write value, then expected readback: reserved bits, read-only, unmapped
    row_t rows [11] = '{'{ADDR_PASS, 8'h00, 8'hff}, '{ADDR_LIMIT_0, 8'h12, 8'h12},
        '{ADDR_LIMIT_1, 8'h34, 8'h34}, '{ADDR_LIMIT_2, 8'h56, 8'h56}, '{ADDR_LANE_EN, 8'ha5, 8'ha5},
        '{ADDR_PAT_CTRL, 8'hfc, 8'h7c}, '{ADDR_SC_CTRL, 8'hfc, 8'h3c}, '{ADDR_EXPECT_A, 8'h9a, 8'h9a},
        '{ADDR_EXPECT_B, 8'hbc, 8'hbc}, '{ADDR_LINK_SEL, 8'h04, 8'h04}, '{15'h401, 8'h5a, 8'h00}};
    always #12.5 clk = ~clk;
    serial_link_test_checker i_dut (.clk, .nrst, .spiCsN, .spiClk, .spiDataIn, .spiDataOut,
        .spiDataOutEn, .laneWords, .laneChars, .linkLaneEnable, .dualLinkMode, .tplFrame,
        .syncRequestOutN);
    link_tx_model i_tx (.clk, .mode, .flipBit, .laneWords, .laneChars, .tplFrame);
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        checks++;
        if (seen !== exp)
        begin
            errTotal++;
            $display("wrong value at %0t: %h expected %h", $time, seen, exp);
        end
    endtask : check
    // one 24-bit frame; read bits are taken at each rising serial clock
    task automatic xfer(input logic r, input logic [14:0] a, input logic [7:0] d);
        logic [23:0] f;
        f = {r, a, d};
        spiCsN <= 1'b0;
        for (int i = 23; i >= 0; i--)
        begin
            spiDataIn <= f[i];
            repeat (2) @(posedge clk);
            spiClk <= 1'b1;
            repeat (2) @(posedge clk);
            if (i < 8)
                q[i] = spiDataOut;
            spiClk <= 1'b0;
        end
        repeat (2) @(posedge clk);
        spiCsN <= 1'b1;
        repeat (3) @(posedge clk);
    endtask : xfer
    task automatic endOfTest;
        $display("checks %0d errors %0d", checks, errTotal);
        if (errTotal == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : endOfTest
    initial
    begin
        nrst <= 1'b0;
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        mode <= 2'h2;
        repeat (4) @(posedge clk);
        foreach (rows[i])
        begin
            xfer(1'b0, rows[i].a, rows[i].d);
            xfer(1'b1, rows[i].a, 8'h00);
            check(q, rows[i].q);
        end
        // two hits of three errors on lane 0: limit 6 fails, 7 passes
        xfer(1'b0, ADDR_LANE_EN, 8'h03);
        for (int k = 0; k < 2; k++)
        begin
            xfer(1'b0, ADDR_PAT_CTRL, 8'h01);
            xfer(1'b0, ADDR_PAT_CTRL, 8'h00);
            xfer(1'b0, ADDR_LIMIT_0, 8'h06 + 8'(k));
            xfer(1'b0, ADDR_LIMIT_1, 8'h00);
            xfer(1'b0, ADDR_LIMIT_2, 8'h00);
            xfer(1'b0, ADDR_PAT_CTRL, 8'h02);
            repeat (2)
            begin
                repeat (8) @(posedge clk);
                flipBit <= 1'b1;
                @(posedge clk);
                flipBit <= 1'b0;
            end
            repeat (8) @(posedge clk);
            xfer(1'b0, ADDR_PAT_CTRL, 8'h00);
            xfer(1'b1, ADDR_PASS, 8'h00);
            check(q, {7'h7f, k[0]});
            xfer(1'b1, ADDR_TALLY_0, 8'h00);
            check(q, 8'h06);
        end
        xfer(1'b0, ADDR_PAT_CTRL, 8'h10);
        xfer(1'b1, ADDR_TALLY_0, 8'h00);
        check(q, 8'h00);
        // converter 2 slot 1 holds 0x0a09: match, sticky miss, clear while off
        mode <= 2'h3;
        xfer(1'b0, ADDR_EXPECT_B, 8'h0a);
        for (int k = 0; k < 3; k++)
        begin
            xfer(1'b0, ADDR_EXPECT_A, (k == 0) ? 8'h09 : 8'h08);
            xfer(1'b0, ADDR_SC_CTRL, (k < 2) ? 8'h1b : 8'h1a);
            xfer(1'b0, ADDR_SC_CTRL, (k < 2) ? 8'h19 : 8'h18);
            xfer(1'b1, ADDR_SC_RESULT, 8'h00);
            check(q, {7'h00, k == 1});
        end
        mode <= 2'h1;
        check(syncRequestOutN, 2'b00);
        linkLaneEnable <= 8'hff;
        for (int n = 0; syncRequestOutN !== 2'b11; n++)
        begin
            if (n == 20)
            begin
                errTotal++;
                endOfTest();
            end
            @(posedge clk);
        end
        for (int k = 0; k < 2; k++)
        begin
            xfer(1'b0, ADDR_LINK_SEL, 8'(k << 2));
            xfer(1'b1, ADDR_CGS_STATUS, 8'h00);
            check(q, 8'h0f);
        end
        nrst <= 1'b0;
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        repeat (4) @(posedge clk);
        xfer(1'b1, ADDR_PAT_CTRL, 8'h00);
        check(q, 8'h00);
        endOfTest();
    end
endmodule : serial_link_test_checker_tb
